// *** verilog/cc_map.svh ***
// register offsets, field positions, reset values and timing for the current converter
`ifndef CC_MAP_SVH
`define CC_MAP_SVH

`define CC_OFS_CTRL_A      4'h0
`define CC_OFS_CTRL_B      4'h1
`define CC_OFS_CHG_THR     4'h2
`define CC_OFS_DIS_THR     4'h3
`define CC_OFS_INST_LO     4'h4
`define CC_OFS_INST_HI     4'h5
`define CC_OFS_ACC_B0      4'h6
`define CC_OFS_ACC_B1      4'h7
`define CC_OFS_ACC_B2      4'h8
`define CC_OFS_ACC_B3      4'h9

`define CC_A_EN            7
`define CC_A_BUSY          5
`define CC_A_AS_HI         4
`define CC_A_AS_LO         3
`define CC_A_SI_HI         2
`define CC_A_SI_LO         1
`define CC_A_SE            0

`define CC_B_ACC_IE        6
`define CC_B_REG_IE        5
`define CC_B_INST_IE       4
`define CC_B_ACC_IF        2
`define CC_B_REG_IF        1
`define CC_B_INST_IF       0

`define CC_RST_CTRL_A      8'h00
`define CC_RST_CTRL_B      8'h00
`define CC_RST_THR         8'h00

`define CC_CLK_NS          10
`define CC_TICK_NS         1000
`define CC_INST_US         3900
`define CC_SAMPLE_US       16000
`define CC_ACC_BASE_US     125000
`define CC_SI_BASE_US      250000

`endif

// *** verilog/cc_pkg.sv ***
// types shared by the current converter control
package cc_pkg;

  typedef enum logic [1:0] {
    CC_OFF    = 2'h0,
    CC_SAMPLE = 2'h1,
    CC_PAUSE  = 2'h3,
    CC_CONT   = 2'h2
  } cc_state_t;

  typedef enum logic [2:0] {
    CC_PM_ACTIVE = 3'h0,
    CC_PM_IDLE   = 3'h1,
    CC_PM_SAVE   = 3'h2,
    CC_PM_DOWN   = 3'h3,
    CC_PM_OFF    = 3'h4
  } cc_pmode_t;

endpackage : cc_pkg

// *** verilog/cc_ctrl.sv ***
// current converter control: decimation, detection mode, flags and registers
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "cc_map.svh"

module cc_ctrl #(
  parameter int TICK_CYCLES  = `CC_TICK_NS / `CC_CLK_NS,
  parameter int INST_TICKS   = `CC_INST_US * 1000 / `CC_TICK_NS,
  parameter int SAMPLE_TICKS = `CC_SAMPLE_US * 1000 / `CC_TICK_NS,
  parameter int ACC_TICKS    = `CC_ACC_BASE_US * 1000 / `CC_TICK_NS,
  parameter int SI_TICKS     = `CC_SI_BASE_US * 1000 / `CC_TICK_NS
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [2:0] pwr_mode,
  input  wire logic       global_irq_en,
  input  wire logic       ack_accumulate,
  input  wire logic       ack_regular,
  input  wire logic       ack_instant,
  output logic            irq_accumulate,
  output logic            irq_regular,
  output logic            irq_instant,
  input  wire logic       mod_bit,
  output logic            mod_power
);

  localparam int CW = 22;

  typedef struct packed {
    cc_pkg::cc_state_t st;
    logic [7:0]        ctl_sh;
    logic              abort_sh;
    logic [7:0]        ctl;
    logic [7:0]        chg_sh;
    logic [7:0]        chg;
    logic [7:0]        dis_sh;
    logic [7:0]        dis;
    logic [2:0]        pend;
    logic [2:0]        ie;
    logic [2:0]        flg;
    logic [6:0]        div;
    logic [CW-1:0]     tcnt;
    logic [CW-1:0]     acnt;
    logic [15:0]       isum;
    logic [31:0]       asum;
    logic [15:0]       inst_lat;
    logic [15:0]       inst_vis;
    logic [31:0]       acc_lat;
    logic [31:0]       acc_vis;
    logic              frz_i;
    logic              frz_a;
    logic [2:0]        sync;
    logic              mod_q;
    logic [7:0]        rdata;
    logic              pwr;
  } cc_ctrl_state_t;

  cc_ctrl_state_t s_r;
  cc_ctrl_state_t s_nxt;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic          tick;
  logic          run;
  logic          inst_done;
  logic          acc_done;
  logic [15:0]   step16;
  logic [31:0]   step32;
  logic [15:0]   inst_new;
  logic [31:0]   acc_new;
  logic [CW-1:0] acc_len;
  logic [CW-1:0] int_len;
  logic          reg_hit;
  logic [15:0]   mag;
  logic [2:0]    flg_set;
  logic [2:0]    flg_clr;
  logic          wr_b;

  always_comb begin
    s_nxt     = s_r;
    inst_done = 1'b0;
    acc_done  = 1'b0;
    reg_hit   = 1'b0;
    mag       = 16'h0000;
    tick      = (s_r.div == 7'(TICK_CYCLES - 1));
    s_nxt.div = tick ? 7'h00 : s_r.div + 7'h01;
    // modulator pin: three stages, a change counts once the last two agree
    s_nxt.sync = {s_r.sync[1:0], mod_bit};
    if (s_r.sync[1] == s_r.sync[2]) begin
      s_nxt.mod_q = s_r.sync[2];
    end
    step16   = s_r.mod_q ? 16'h0001 : 16'hffff;
    step32   = s_r.mod_q ? 32'h00000001 : 32'hffffffff;
    inst_new = s_r.isum + step16;
    acc_new  = s_r.asum + step32;
    acc_len  = CW'(ACC_TICKS) << s_r.ctl[`CC_A_AS_HI:`CC_A_AS_LO];
    int_len  = CW'(SI_TICKS) << s_r.ctl[`CC_A_SI_HI:`CC_A_SI_LO];
    run      = s_r.ctl[`CC_A_EN]
               && (pwr_mode != cc_pkg::CC_PM_DOWN)
               && (pwr_mode != cc_pkg::CC_PM_OFF);

    // bus writes; synchronised registers refuse a write while still crossing
    if (wr && hit(addr, `CC_OFS_CTRL_A) && !s_r.pend[0]) begin
      s_nxt.ctl_sh   = wdata & 8'hbf;
      s_nxt.abort_sh = wdata[`CC_A_SE];
      s_nxt.pend[0]  = 1'b1;
    end
    if (wr && hit(addr, `CC_OFS_CHG_THR) && !s_r.pend[1]) begin
      s_nxt.chg_sh  = wdata;
      s_nxt.pend[1] = 1'b1;
    end
    if (wr && hit(addr, `CC_OFS_DIS_THR) && !s_r.pend[2]) begin
      s_nxt.dis_sh  = wdata;
      s_nxt.pend[2] = 1'b1;
    end
    wr_b = wr && hit(addr, `CC_OFS_CTRL_B);
    if (wr_b) begin
      s_nxt.ie = {wdata[`CC_B_ACC_IE], wdata[`CC_B_REG_IE], wdata[`CC_B_INST_IE]};
    end

    // converter timing, advanced once per tick
    if (tick) begin
      if (!run) begin
        s_nxt.st   = cc_pkg::CC_OFF;
        s_nxt.tcnt = '0;
        s_nxt.acnt = '0;
        s_nxt.isum = 16'h0000;
        s_nxt.asum = 32'h00000000;
      end else begin
        case (s_r.st)
          cc_pkg::CC_OFF: begin
            s_nxt.st = s_r.ctl[`CC_A_SE] ? cc_pkg::CC_SAMPLE : cc_pkg::CC_CONT;
          end
          cc_pkg::CC_CONT: begin
            s_nxt.tcnt = s_r.tcnt + CW'(1);
            s_nxt.acnt = s_r.acnt + CW'(1);
            s_nxt.isum = inst_new;
            s_nxt.asum = acc_new;
            if (s_r.tcnt == CW'(INST_TICKS - 1)) begin
              inst_done  = 1'b1;
              s_nxt.tcnt = '0;
              s_nxt.isum = 16'h0000;
            end
            // a period shortened mid-count ends at once rather than waiting for a wrap
            if (s_r.acnt >= acc_len - CW'(1)) begin
              acc_done   = 1'b1;
              s_nxt.acnt = '0;
              s_nxt.asum = 32'h00000000;
            end
            if (s_r.ctl[`CC_A_SE]) begin
              s_nxt.st   = cc_pkg::CC_SAMPLE;
              s_nxt.tcnt = '0;
              s_nxt.isum = 16'h0000;
            end
          end
          cc_pkg::CC_SAMPLE: begin
            s_nxt.tcnt = s_r.tcnt + CW'(1);
            s_nxt.isum = inst_new;
            if (s_r.tcnt == CW'(SAMPLE_TICKS - 1)) begin
              inst_done  = 1'b1;
              s_nxt.st   = cc_pkg::CC_PAUSE;
              s_nxt.tcnt = '0;
              s_nxt.isum = 16'h0000;
            end
            if (!s_r.ctl[`CC_A_SE]) begin
              s_nxt.st   = cc_pkg::CC_CONT;
              s_nxt.tcnt = '0;
              s_nxt.isum = 16'h0000;
            end
          end
          cc_pkg::CC_PAUSE: begin
            s_nxt.tcnt = s_r.tcnt + CW'(1);
            if (s_r.tcnt >= int_len - CW'(1)) begin
              s_nxt.st   = cc_pkg::CC_SAMPLE;
              s_nxt.tcnt = '0;
            end
            if (!s_r.ctl[`CC_A_SE]) begin
              s_nxt.st   = cc_pkg::CC_CONT;
              s_nxt.tcnt = '0;
            end
          end
          default: begin
            s_nxt.st = cc_pkg::CC_OFF;
          end
        endcase
      end
      // pending writes land in converter timing on the tick
      if (s_r.pend[0]) begin
        s_nxt.ctl      = s_r.ctl_sh;
        s_nxt.abort_sh = 1'b0;
        if (s_r.abort_sh && s_r.ctl_sh[`CC_A_EN] && (pwr_mode != cc_pkg::CC_PM_DOWN)
            && (pwr_mode != cc_pkg::CC_PM_OFF)) begin
          s_nxt.st   = cc_pkg::CC_SAMPLE;
          s_nxt.tcnt = '0;
          s_nxt.acnt = '0;
          s_nxt.isum = 16'h0000;
          s_nxt.asum = 32'h00000000;
          inst_done  = 1'b0;
          acc_done   = 1'b0;
        end
      end
      if (s_r.pend[1]) begin
        s_nxt.chg = s_r.chg_sh;
      end
      if (s_r.pend[2]) begin
        s_nxt.dis = s_r.dis_sh;
      end
      s_nxt.pend = s_nxt.pend & ~s_r.pend;
    end

    // results and regular-current compare
    if (inst_done) begin
      s_nxt.inst_lat = inst_new;
      mag            = 16'h0000 - inst_new;
      reg_hit        = inst_new[15] ? (mag >= {8'h00, s_r.dis})
                                    : (inst_new >= {8'h00, s_r.chg});
    end
    if (acc_done) begin
      s_nxt.acc_lat = acc_new;
    end
    // the low-byte read already holds the value, so all bytes match
    if (!s_r.frz_i && !(rd && hit(addr, `CC_OFS_INST_LO))) begin
      s_nxt.inst_vis = s_nxt.inst_lat;
    end
    if (!s_r.frz_a && !(rd && hit(addr, `CC_OFS_ACC_B0))) begin
      s_nxt.acc_vis = s_nxt.acc_lat;
    end

    // flags: an event in the clearing cycle wins
    flg_set   = {acc_done, reg_hit, inst_done};
    flg_clr   = {ack_accumulate, ack_regular, ack_instant}
                | (wr_b ? {wdata[`CC_B_ACC_IF], wdata[`CC_B_REG_IF], wdata[`CC_B_INST_IF]} : 3'b000);
    s_nxt.flg = (s_r.flg & ~flg_clr) | flg_set;

    // reads: data in the next cycle, byte reads steer the freeze
    s_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `CC_OFS_CTRL_A:  s_nxt.rdata = {s_r.ctl_sh[7], 1'b0, |s_r.pend, s_r.ctl_sh[4:0]};
        `CC_OFS_CTRL_B:  s_nxt.rdata = {1'b0, s_r.ie, 1'b0, s_r.flg};
        `CC_OFS_CHG_THR: s_nxt.rdata = s_r.chg_sh;
        `CC_OFS_DIS_THR: s_nxt.rdata = s_r.dis_sh;
        `CC_OFS_INST_LO: s_nxt.rdata = s_r.inst_vis[7:0];
        `CC_OFS_INST_HI: s_nxt.rdata = s_r.inst_vis[15:8];
        `CC_OFS_ACC_B0:  s_nxt.rdata = s_r.acc_vis[7:0];
        `CC_OFS_ACC_B1:  s_nxt.rdata = s_r.acc_vis[15:8];
        `CC_OFS_ACC_B2:  s_nxt.rdata = s_r.acc_vis[23:16];
        `CC_OFS_ACC_B3:  s_nxt.rdata = s_r.acc_vis[31:24];
        default:         s_nxt.rdata = 8'h00;
      endcase
      if (hit(addr, `CC_OFS_INST_LO)) begin
        s_nxt.frz_i = 1'b1;
      end
      if (hit(addr, `CC_OFS_INST_HI)) begin
        s_nxt.frz_i = 1'b0;
      end
      if (hit(addr, `CC_OFS_ACC_B0)) begin
        s_nxt.frz_a = 1'b1;
      end
      if (hit(addr, `CC_OFS_ACC_B3)) begin
        s_nxt.frz_a = 1'b0;
      end
    end
    s_nxt.pwr = (s_nxt.st == cc_pkg::CC_CONT) || (s_nxt.st == cc_pkg::CC_SAMPLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r          <= '0;
      s_r.st       <= cc_pkg::CC_OFF;
      s_r.ctl_sh   <= `CC_RST_CTRL_A;
      s_r.ctl      <= `CC_RST_CTRL_A;
      s_r.chg_sh   <= `CC_RST_THR;
      s_r.chg      <= `CC_RST_THR;
      s_r.dis_sh   <= `CC_RST_THR;
      s_r.dis      <= `CC_RST_THR;
      s_r.ie       <= 3'b000;
      s_r.flg      <= 3'b000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata          = s_r.rdata;
  assign mod_power      = s_r.pwr;
  assign irq_accumulate = s_r.flg[2] && s_r.ie[2] && global_irq_en;
  assign irq_regular    = s_r.flg[1] && s_r.ie[1] && global_irq_en;
  assign irq_instant    = s_r.flg[0] && s_r.ie[0] && global_irq_en;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_inst_period_flag: assert property (
    (s_r.st == cc_pkg::CC_CONT && run && tick && !s_r.pend[0] && s_r.tcnt == CW'(INST_TICKS - 1))
    |=> s_r.flg[0] && s_r.tcnt == '0)
    else $error("instant period end did not set the instant flag");
  a_irq_global_gate: assert property (
    !global_irq_en |-> !irq_accumulate && !irq_regular && !irq_instant)
    else $error("request raised without global enable");
  a_busy_readback: assert property (
    (rd && addr == `CC_OFS_CTRL_A) |=> rdata[`CC_A_BUSY] == $past(|s_r.pend))
    else $error("busy bit does not match pending transfers");
  a_thr_write_block: assert property (
    (wr && addr == `CC_OFS_CHG_THR && s_r.pend[1]) |=> s_r.chg_sh == $past(s_r.chg_sh))
    else $error("threshold write not blocked while crossing");
  a_power_off_stop: assert property (
    (pwr_mode == cc_pkg::CC_PM_OFF && tick) |=> s_r.st == cc_pkg::CC_OFF ##1 !mod_power)
    else $error("converter kept running in power-off");
  a_reserved_zero: assert property (
    (rd && (addr == `CC_OFS_CTRL_A || addr == `CC_OFS_CTRL_B))
    |=> (($past(addr) == `CC_OFS_CTRL_A) ? !rdata[6] : (!rdata[7] && !rdata[3])))
    else $error("reserved bit read as one");
  a_inst_freeze: assert property (
    (s_r.frz_i && !(rd && addr == `CC_OFS_INST_HI)) |=> $stable(s_r.inst_vis))
    else $error("instant result changed while frozen");
  a_sample_abort: assert property (
    (tick && run && s_r.pend[0] && s_r.abort_sh && s_r.ctl_sh[`CC_A_EN])
    |=> s_r.st == cc_pkg::CC_SAMPLE && s_r.tcnt == '0 ##1 mod_power)
    else $error("sampling enable write did not abort into detection");
  a_ctrl_write_lands: assert property (
    (tick && s_r.pend[0]) |=> s_r.ctl == $past(s_r.ctl_sh) && !s_r.pend[0])
    else $error("control write did not land on the tick");
  a_disable_stops: assert property (
    (tick && !s_r.ctl[`CC_A_EN] && !s_r.pend[0]) |=> s_r.st == cc_pkg::CC_OFF)
    else $error("converter kept running after enable cleared");
  a_down_stops: assert property (
    (tick && pwr_mode == cc_pkg::CC_PM_DOWN) |=> s_r.st == cc_pkg::CC_OFF ##1 !mod_power)
    else $error("converter kept running in power-down");
  a_wake_resumes: assert property (
    (tick && run && s_r.st == cc_pkg::CC_OFF && !s_r.ctl[`CC_A_SE] && !s_r.pend[0])
    |=> s_r.st == cc_pkg::CC_CONT ##1 mod_power)
    else $error("converter did not resume continuous conversion");
  a_sample_pause: assert property (
    (tick && run && s_r.st == cc_pkg::CC_SAMPLE && s_r.ctl[`CC_A_SE] && !s_r.pend[0]
     && s_r.tcnt == CW'(SAMPLE_TICKS - 1))
    |=> s_r.st == cc_pkg::CC_PAUSE && !mod_power && s_r.flg[0])
    else $error("sample did not end in a pause with a result");
  a_ack_clears: assert property (
    (ack_instant && !inst_done) |=> !s_r.flg[0])
    else $error("instant flag not cleared by the vector");
  a_write_one_clears: assert property (
    (wr_b && wdata[`CC_B_REG_IF] && !reg_hit) |=> !s_r.flg[1])
    else $error("regular flag not cleared by writing one");

endmodule : cc_ctrl

// *** bench/cc_modulator.sv ***
// behavioural sigma-delta modulator standing across the sense resistor
`timescale 1ns/1ps

module cc_modulator (
  input  wire logic clk,
  input  wire logic powered,
  input  wire logic ref_on,
  input  wire logic level,
  output logic      bit_out
);
  initial bit_out = 1'b0;
  // powered with reference: constant density set by level; otherwise toggles so no stale value survives
  always @(posedge clk) begin
    bit_out <= (powered && ref_on) ? level : ~bit_out;
  end
endmodule : cc_modulator

// *** bench/test_cc_ctrl.sv ***
// self-checking bench for the current converter control
`timescale 1ns/1ps
`include "cc_map.svh"

module test_cc_ctrl;
  localparam int TCY  = 8;
  localparam int INST = 5;
  localparam int SMP  = 8;
  localparam int ACC  = 10;
  localparam int SI   = 6;
  localparam logic [3:0] RA = `CC_OFS_CTRL_A;
  localparam logic [3:0] RB = `CC_OFS_CTRL_B;
  typedef struct {logic [7:0] e; logic [7:0] m;} cc_exp_t;
  logic       clk, arst_n, wr, rd, gie, mod_bit, mod_power, level, rd_q, ref_en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, thr;
  logic [2:0] pwr_mode, ack, irq;
  wire  [3:0] mon = {mod_power, irq};
  int         miscompares, comparisons, cyc, t0, t1, t2, n;
  integer     seed;
  cc_exp_t    q[$];
  cc_exp_t    x;

  cc_ctrl #(.TICK_CYCLES(TCY), .INST_TICKS(INST), .SAMPLE_TICKS(SMP), .ACC_TICKS(ACC), .SI_TICKS(SI)) i_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pwr_mode(pwr_mode), .global_irq_en(gie), .ack_accumulate(ack[2]), .ack_regular(ack[1]),
    .ack_instant(ack[0]), .irq_accumulate(irq[2]), .irq_regular(irq[1]), .irq_instant(irq[0]),
    .mod_bit(mod_bit), .mod_power(mod_power));
  cc_modulator i_mod (.clk(clk), .powered(mod_power), .ref_on(ref_en), .level(level), .bit_out(mod_bit));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    rd_q <= rd;
  end
  // read data stand only in the cycle after the strobe
  always @(negedge clk) if (rd_q === 1'b1) begin
    x = q.pop_front();
    check(rdata & x.m, x.e & x.m);
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic cy(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d,
                    input logic [7:0] e = 8'h00, input logic [7:0] m = 8'hff);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r) q.push_back('{e, m});
  endtask : cy
  task automatic idle(input int k = 1);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (k - 1) @(posedge clk);
  endtask : idle
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    cy(1'b1, 1'b0, a, d);
    idle();
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    cy(1'b0, 1'b1, a, 8'h00, e, m);
    idle();
  endtask : rreg
  task automatic wsig(input int s, input logic v, output int t);
    int k;
    k = 0;
    @(negedge clk);
    while (mon[s] !== v && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k == 5000) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, mon[s], v);
    end
    t = cyc;
  endtask : wsig
  task automatic pk(input int s);
    @(posedge clk);
    ack[s] <= 1'b1;
    @(posedge clk);
    ack[s] <= 1'b0;
  endtask : pk
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #400_000;
    miscompares++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 0, 1);
    stop_test();
  end

  initial begin
    seed = 32'h056f;
    {arst_n, wr, rd, gie, level, ref_en, ack, pwr_mode, addr, wdata} = '0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 11; a++) rreg(a[3:0], 8'h00);
    wreg(RB, 8'hff);
    rreg(RB, 8'h70);
    ref_en <= 1'b1;
    wreg(RA, 8'h80);
    level <= 1'b1;
    gie <= 1'b1;
    $display("test reset and map done");
    wsig(0, 1'b1, t0);
    pk(0);
    wsig(0, 1'b1, t1);
    pk(0);
    wsig(0, 1'b1, t2);
    check(t1 - t0, INST * TCY);
    check(t2 - t1, INST * TCY);
    // back-to-back writes right after a tick, then busy read
    cy(1'b1, 1'b0, RA, 8'h86);
    cy(1'b1, 1'b0, RA, 8'h00);
    cy(1'b1, 1'b0, `CC_OFS_CHG_THR, 8'h05);
    cy(1'b1, 1'b0, `CC_OFS_DIS_THR, 8'h05);
    cy(1'b0, 1'b1, RA, 8'h00, 8'ha6);
    idle(3 * TCY);
    rreg(RA, 8'h86);
    rreg(`CC_OFS_CHG_THR, 8'h05);
    rreg(`CC_OFS_DIS_THR, 8'h05);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (mod_power !== 1'b1) n++;
    end
    check(n, 0);
    $display("test sync and busy done");
    for (int s = 0; s < 4; s++) begin
      wreg(RA, {3'b100, s[1:0], 3'b000});
      wsig(2, 1'b1, t0);
      pk(2);
      wsig(2, 1'b1, t1);
      pk(2);
      wsig(2, 1'b1, t2);
      pk(2);
      check(t2 - t1, (ACC << s) * TCY);
    end
    wreg(RA, 8'h80);
    idle(5 * ACC * TCY);
    rreg(`CC_OFS_INST_LO, 8'h05);
    rreg(`CC_OFS_ACC_B0, 8'h0a);
    level <= 1'b0;
    idle(5 * ACC * TCY);
    rreg(`CC_OFS_INST_HI, 8'h00);
    for (int b = 7; b < 10; b++) rreg(b[3:0], 8'h00);
    rreg(`CC_OFS_INST_LO, 8'hfb);
    rreg(`CC_OFS_INST_HI, 8'hff);
    rreg(`CC_OFS_ACC_B0, 8'hf6);
    for (int b = 7; b < 10; b++) rreg(b[3:0], 8'hff);
    $display("test results done");
    for (int i = 0; i < 6; i++) begin
      thr = 8'($random(seed)) & 8'h07;
      level <= i[0];
      wreg(i[0] ? `CC_OFS_CHG_THR : `CC_OFS_DIS_THR, thr);
      idle(5 * INST * TCY);
      wreg(RB, 8'h77);
      idle(3 * INST * TCY);
      rreg(RB, {6'h00, thr <= 8'h05, 1'b0}, 8'h02);
    end
    for (int k = 0; k < 4; k++) begin
      gie <= k[0];
      wreg(RB, {1'b0, {3{k[1]}}, 4'h0});
      idle(2);
      @(negedge clk);
      check(irq[0], k[0] & k[1]);
      check(irq[1], k[0] & k[1] & (thr <= 8'h05));
      check(irq[2], k[0] & k[1]);
    end
    pk(0);
    wsig(0, 1'b1, t0);
    cy(1'b1, 1'b0, RB, 8'h71);
    cy(1'b0, 1'b1, RB, 8'h00, 8'h70, 8'h71);
    idle();
    wsig(0, 1'b1, t0);
    pk(0);
    rreg(RB, 8'h70, 8'h71);
    $display("test flags done");
    for (int m = 0; m < 5; m++) begin
      @(posedge clk);
      pwr_mode <= m[2:0];
      idle(3 * TCY);
      @(negedge clk);
      check(mod_power, m < 3);
      @(posedge clk);
      pwr_mode <= 3'h0;
      idle(3 * TCY);
      @(negedge clk);
      check(mod_power, 1'b1);
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      pwr_mode <= (s == 3) ? 3'h2 : 3'h0;
      wreg(RA, {5'b10000, s[1:0], 1'b1});
      wsig(3, 1'b0, t0);
      wsig(3, 1'b1, t0);
      wsig(3, 1'b0, t1);
      wsig(3, 1'b1, t2);
      check(t1 - t0, SMP * TCY);
      check(t2 - t1, (SI << s) * TCY);
    end
    $display("test power and detection done");
    wreg(RA, 8'h00);
    idle(3 * TCY);
    wreg(RB, 8'h77);
    idle(3 * INST * TCY);
    rreg(RB, 8'h70);
    @(negedge clk);
    check(mod_power, 1'b0);
    $display("test disable done");
    stop_test();
  end
endmodule : test_cc_ctrl
